// File: src/ppc_port_power_protection_ctrl.v
// Thermal loop, VBUS discharge and charge rationing control with AXI4-Lite registers
`timescale 1ns/1ps
`include "ppc_map.vh"

// Summary of operation
// - Thermal loop runs in both limiting modes
// - Over regulation: open switch, step down, retry
// - Retry expiry recloses switch once cool, else steps again until minimum
// - CC at minimum: go trip, floor 100mA, restart one step below programmed limit
// - Cool after forced trip: timer then restore CC
// - Cool otherwise: restore configuration at once
// - Trip at minimum hot: switch closed, hold minimum
// - Hot during charger cycle drops profile until change
// - Regulation overtemperature never starts discharge
// - Shutdown temperature forces switch off until hysteresis
// - Discharge on listed trigger events
// - Discharge on command while Active, and on bypass source swaps
// - Failed discharge check sets flag, enters Error
// - Accumulate charge only when Active, compare limit
// - Limit reached runs behaviour, never Error
// - Behaviour held until rationing reset or disable
// - Behaviour field decode: report, disconnect, sleep, ignore
// - Disconnect behaviour: alert, drop profile, switch off
// - Disconnect keeps data path, monitoring, bypass off
// - Sleep behaviour: stop everything, ignore control changes
// - Rationing reset clears total, flag and alert
module ppc_port_power_protection_ctrl #(
  parameter LIMIT_W = 3,
  parameter integer RETRY_CYCLES = `PPC_RETRY_MS * (`PPC_CLK_HZ / 1000),
  parameter integer RESTORE_CYCLES = `PPC_CC_RESTORE_MS * (`PPC_CLK_HZ / 1000),
  parameter integer DISCHARGE_CYCLES = `PPC_DISCHARGE_MS * (`PPC_CLK_HZ / 1000),
  parameter integer TICK_CYCLES = `PPC_TICK_MS * (`PPC_CLK_HZ / 1000)
) (
  // Clock and reset
  input wire clock,
  input wire srst,
  // AXI4-Lite slave
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Comparator inputs from the analog side
  input wire overRegTemp,
  input wire regTempReleased,
  input wire overShutdownTemp,
  input wire shutdownTempReleased,
  input wire sourceUndervoltage,
  input wire vbusBelowCheckLevel,
  // Power state and control pins
  input wire portPowerRequest,
  input wire removalDetect,
  input wire sleepCommand,
  input wire errorRecover,
  input wire profileApply,
  input wire bypassSelected,
  input wire activeState,
  input wire chargerCycleAccepted,
  input wire controlsChanged,
  input wire [15:0] busCurrentMa,
  // Switch and profile outputs
  output reg portSwitchOn,
  output reg [LIMIT_W-1:0] portCurrentLimit,
  output reg constantCurrentLimiting,
  output reg [15:0] ccCurrentFloor,
  output reg dischargeOn,
  output reg errorState,
  output reg profileEnable,
  output reg forceSleep,
  output reg dataPathSwitchEn,
  output reg monitorEn,
  output reg bypassBlock,
  output reg alertN
);

  localparam TH_NORMAL = 2'h0;
  localparam TH_WAIT = 2'h1;
  localparam TH_HOLD = 2'h2;
  localparam TH_RESTORE = 2'h3;

  // Two-flop synchronisers for everything arriving from pins or analog
  localparam NSYNC = 14;
  wire [NSYNC-1:0] rawIn = {overRegTemp, regTempReleased, overShutdownTemp,
    shutdownTempReleased, sourceUndervoltage, vbusBelowCheckLevel, portPowerRequest,
    removalDetect, sleepCommand, errorRecover, profileApply, bypassSelected,
    chargerCycleAccepted, controlsChanged};
  reg [NSYNC-1:0] meta_q;
  reg [NSYNC-1:0] sync_q;
  reg [NSYNC-1:0] prev_q;
  always @(posedge clock) begin
    if (srst) begin
      meta_q <= {NSYNC{1'b0}};
      sync_q <= {NSYNC{1'b0}};
      prev_q <= {NSYNC{1'b0}};
    end else begin
      meta_q <= rawIn;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end
  wire hotReg = sync_q[13];
  wire coolReg = sync_q[12];
  wire hotTsd = sync_q[11];
  wire coolTsd = sync_q[10];
  wire uvRise = sync_q[9] & ~prev_q[9];
  wire vbusLow = sync_q[8];
  wire pwrFall = ~sync_q[7] & prev_q[7];
  wire removalRise = sync_q[6] & ~prev_q[6];
  wire sleepRise = sync_q[5] & ~prev_q[5];
  wire recoverRise = sync_q[4] & ~prev_q[4];
  wire profileRise = sync_q[3] & ~prev_q[3];
  wire bypassEdge = sync_q[2] ^ prev_q[2];
  wire dceAccepted = sync_q[1];
  wire ctrlRise = sync_q[0] & ~prev_q[0];
  reg activeSync_q;
  reg activeMeta_q;
  reg [15:0] curMeta_q;
  reg [15:0] curSync_q;

  // Registers written by software, plus status and charge state
  reg [31:0] ctrl_q;
  reg [31:0] limit_q;
  reg [31:0] reached_flag_a_q;
  reg dischargeErr_q;
  reg rationReached_q;
  reg [31:0] charge_q;
  reg [31:0] chargeMaSec_q;
  wire rationEn = ctrl_q[`PPC_CTRL_REACHED_FLAG_A_EN];
  wire [1:0] beh = ctrl_q[`PPC_CTRL_BEH_HI:`PPC_CTRL_BEH_LO];

  // Write channel: both address and data accepted together, one write at a time
  wire wrGo = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_awready = wrGo;
  assign s_axi_wready = wrGo;
  wire rdGo = s_axi_arvalid & ~s_axi_rvalid;
  assign s_axi_arready = rdGo;
  wire wrCtrl = wrGo & (s_axi_awaddr == `PPC_OFF_CTRL);
  wire rationRst = wrCtrl & s_axi_wstrb[0] & s_axi_wdata[`PPC_CTRL_REACHED_FLAG_A_RST];
  wire dischCmd = wrCtrl & s_axi_wstrb[0] & s_axi_wdata[`PPC_CTRL_DISCH_CMD];

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  function mapped;
    input [11:0] a;
    begin
      mapped = (a == `PPC_OFF_CTRL) | (a == `PPC_OFF_LIMIT) | (a == `PPC_OFF_REACHED_FLAG_A) |
        (a == `PPC_OFF_STATUS) | (a == `PPC_OFF_CHARGE);
    end
  endfunction

  // Bus slave: pulse bits of control never stored, unmapped gives SLVERR
  always @(posedge clock) begin
    if (srst) begin
      ctrl_q <= `PPC_CTRL_RESET;
      limit_q <= `PPC_LIMIT_RESET;
      reached_flag_a_q <= `PPC_REACHED_FLAG_A_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h00000000;
    end else begin
      if (wrGo) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(s_axi_awaddr) ? 2'h0 : 2'h2;
        if (s_axi_awaddr == `PPC_OFF_CTRL)
          ctrl_q <= merge(ctrl_q, s_axi_wdata, s_axi_wstrb) & 32'h00000039;
        if (s_axi_awaddr == `PPC_OFF_LIMIT)
          limit_q <= merge(limit_q, s_axi_wdata, s_axi_wstrb) & {{(32-LIMIT_W){1'b0}},
            {LIMIT_W{1'b1}}};
        if (s_axi_awaddr == `PPC_OFF_REACHED_FLAG_A)
          reached_flag_a_q <= merge(reached_flag_a_q, s_axi_wdata, s_axi_wstrb);
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rdGo) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= mapped(s_axi_araddr) ? 2'h0 : 2'h2;
        case (s_axi_araddr)
          `PPC_OFF_CTRL: s_axi_rdata <= ctrl_q;
          `PPC_OFF_LIMIT: s_axi_rdata <= limit_q;
          `PPC_OFF_REACHED_FLAG_A: s_axi_rdata <= reached_flag_a_q;
          `PPC_OFF_STATUS: s_axi_rdata <= {24'h000000, constantCurrentLimiting,
            portSwitchOn, hotTsd, hotReg, rationReached_q, dischargeErr_q, errorState,
            dischargeOn};
          `PPC_OFF_CHARGE: s_axi_rdata <= charge_q;
          default: s_axi_rdata <= 32'h00000000;
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Thermal regulation loop, applies in trip and constant-current modes alike
  reg [1:0] thState_q;
  reg [31:0] thTimer_q;
  reg forcedTrip_q;
  reg regOpen_q;
  reg profileDrop_q;
  wire [LIMIT_W-1:0] progLimit = limit_q[LIMIT_W-1:0];
  wire progCc = ctrl_q[`PPC_CTRL_CC_MODE];
  always @(posedge clock) begin
    if (srst) begin
      thState_q <= TH_NORMAL;
      thTimer_q <= 32'h00000000;
      forcedTrip_q <= 1'b0;
      regOpen_q <= 1'b0;
      portCurrentLimit <= {LIMIT_W{1'b0}};
      constantCurrentLimiting <= 1'b0;
      ccCurrentFloor <= 16'h0000;
      profileDrop_q <= 1'b0;
    end else begin
      if (hotReg & dceAccepted)
        profileDrop_q <= 1'b1;
      else if (ctrlRise)
        profileDrop_q <= 1'b0;
      case (thState_q)
        TH_NORMAL: begin
          portCurrentLimit <= progLimit;
          constantCurrentLimiting <= progCc;
          ccCurrentFloor <= 16'h0000;
          forcedTrip_q <= 1'b0;
          if (hotReg) begin
            regOpen_q <= 1'b1;
            if (progLimit != {LIMIT_W{1'b0}})
              portCurrentLimit <= progLimit - 1'b1;
            thTimer_q <= RETRY_CYCLES;
            thState_q <= TH_WAIT;
          end
        end
        TH_WAIT: begin
          if (thTimer_q != 32'h00000000) begin
            thTimer_q <= thTimer_q - 1'b1;
          end else begin
            regOpen_q <= 1'b0;
            if (!hotReg) begin
              if (coolReg)
                thState_q <= forcedTrip_q ? TH_RESTORE : TH_NORMAL;
              else
                thState_q <= TH_HOLD;
              thTimer_q <= RESTORE_CYCLES;
            end else if (portCurrentLimit != {LIMIT_W{1'b0}}) begin
              regOpen_q <= 1'b1;
              portCurrentLimit <= portCurrentLimit - 1'b1;
              thTimer_q <= RETRY_CYCLES;
            end else if (constantCurrentLimiting) begin
              constantCurrentLimiting <= 1'b0;
              forcedTrip_q <= 1'b1;
              ccCurrentFloor <= `PPC_FLOOR_TRIP_MA;
              portCurrentLimit <= (progLimit != {LIMIT_W{1'b0}}) ? progLimit - 1'b1 :
                progLimit;
              regOpen_q <= 1'b1;
              thTimer_q <= RETRY_CYCLES;
            end else begin
              thState_q <= TH_HOLD;
            end
          end
        end
        TH_HOLD: begin
          // Switch closed at the limit reached until hysteresis release
          regOpen_q <= 1'b0;
          thTimer_q <= RESTORE_CYCLES;
          if (coolReg)
            thState_q <= forcedTrip_q ? TH_RESTORE : TH_NORMAL;
        end
        TH_RESTORE: begin
          if (hotReg) begin
            thState_q <= TH_HOLD;
          end else if (thTimer_q != 32'h00000000) begin
            thTimer_q <= thTimer_q - 1'b1;
          end else begin
            thState_q <= TH_NORMAL;
          end
        end
        default: thState_q <= TH_NORMAL;
      endcase
    end
  end

  // Shutdown stage latches off until the hysteresis release input
  reg tsdOff_q;
  always @(posedge clock) begin
    if (srst)
      tsdOff_q <= 1'b0;
    else if (hotTsd)
      tsdOff_q <= 1'b1;
    else if (coolTsd)
      tsdOff_q <= 1'b0;
  end

  // Discharge window; regulation events are deliberately not a trigger
  wire dischTrig = pwrFall | removalRise | uvRise | sleepRise | profileRise | recoverRise |
    (dischCmd & activeSync_q) | bypassEdge;
  reg [31:0] discTimer_q;
  always @(posedge clock) begin
    if (srst) begin
      dischargeOn <= 1'b0;
      discTimer_q <= 32'h00000000;
      dischargeErr_q <= 1'b0;
      errorState <= 1'b0;
    end else begin
      if (dischTrig) begin
        dischargeOn <= 1'b1;
        discTimer_q <= DISCHARGE_CYCLES;
      end else if (dischargeOn) begin
        if (discTimer_q != 32'h00000000) begin
          discTimer_q <= discTimer_q - 1'b1;
        end else begin
          dischargeOn <= 1'b0;
          if (!vbusLow) begin
            dischargeErr_q <= 1'b1;
            errorState <= 1'b1;
          end
        end
      end
      if (recoverRise & ~(dischargeOn & discTimer_q == 32'h00000000 & ~vbusLow))
        errorState <= 1'b0;
    end
  end

  // Charge accumulation: mA summed every millisecond, total in mAh
  reg [31:0] tick_q;
  wire tick = (tick_q == 32'h00000000);
  localparam [31:0] MA_MS_PER_MAH = 32'd3600000;
  always @(posedge clock) begin
    if (srst) begin
      activeMeta_q <= 1'b0;
      activeSync_q <= 1'b0;
      curMeta_q <= 16'h0000;
      curSync_q <= 16'h0000;
      tick_q <= 32'h00000000;
      chargeMaSec_q <= 32'h00000000;
      charge_q <= 32'h00000000;
      rationReached_q <= 1'b0;
    end else begin
      activeMeta_q <= activeState;
      activeSync_q <= activeMeta_q;
      curMeta_q <= busCurrentMa;
      curSync_q <= curMeta_q;
      tick_q <= tick ? TICK_CYCLES - 1 : tick_q - 1'b1;
      if (rationRst | ~rationEn) begin
        chargeMaSec_q <= 32'h00000000;
        charge_q <= 32'h00000000;
        rationReached_q <= 1'b0;
      end else begin
        if (tick & activeSync_q) begin
          if (chargeMaSec_q + curSync_q >= MA_MS_PER_MAH) begin
            chargeMaSec_q <= chargeMaSec_q + curSync_q - MA_MS_PER_MAH;
            charge_q <= charge_q + 1'b1;
          end else begin
            chargeMaSec_q <= chargeMaSec_q + curSync_q;
          end
        end
        if (charge_q >= reached_flag_a_q)
          rationReached_q <= 1'b1;
      end
    end
  end

  // Behaviour outputs; Error is never entered from the rationing path
  always @(posedge clock) begin
    if (srst) begin
      portSwitchOn <= 1'b0;
      profileEnable <= 1'b0;
      forceSleep <= 1'b0;
      dataPathSwitchEn <= 1'b1;
      monitorEn <= 1'b1;
      bypassBlock <= 1'b0;
      alertN <= 1'b1;
    end else begin
      alertN <= ~(rationReached_q & (beh == `PPC_BEH_REPORT |
        beh == `PPC_BEH_DISCONNECT));
      profileEnable <= ~profileDrop_q & ~(rationReached_q & (beh == `PPC_BEH_DISCONNECT |
        beh == `PPC_BEH_SLEEP));
      forceSleep <= rationReached_q & (beh == `PPC_BEH_SLEEP);
      dataPathSwitchEn <= ~(rationReached_q & (beh == `PPC_BEH_SLEEP));
      monitorEn <= ~(rationReached_q & (beh == `PPC_BEH_SLEEP));
      bypassBlock <= rationReached_q & (beh == `PPC_BEH_DISCONNECT);
      portSwitchOn <= activeSync_q & ~regOpen_q & ~tsdOff_q & ~hotTsd & ~dischargeOn &
        ~errorState & ~(rationReached_q & beh != `PPC_BEH_IGNORE &
        beh != `PPC_BEH_REPORT);
    end
  end

endmodule

// File: src/ppc_map.vh
// Register offsets, field positions, reset values, clock rate and millisecond timings for the port power controller
`ifndef PPC_MAP_VH
`define PPC_MAP_VH
`define PPC_OFF_CTRL 12'h000
`define PPC_OFF_LIMIT 12'h004
`define PPC_OFF_REACHED_FLAG_A 12'h008
`define PPC_OFF_STATUS 12'h00c
`define PPC_OFF_CHARGE 12'h010
`define PPC_CTRL_REACHED_FLAG_A_EN 0
`define PPC_CTRL_REACHED_FLAG_A_RST 1
`define PPC_CTRL_DISCH_CMD 2
`define PPC_CTRL_CC_MODE 3
`define PPC_CTRL_BEH_LO 4
`define PPC_CTRL_BEH_HI 5
`define PPC_CTRL_RESET 32'h00000010
`define PPC_LIMIT_RESET 32'h00000007
`define PPC_REACHED_FLAG_A_RESET 32'h0000ffff
`define PPC_BEH_REPORT 2'h0
`define PPC_BEH_DISCONNECT 2'h1
`define PPC_BEH_SLEEP 2'h2
`define PPC_BEH_IGNORE 2'h3
`define PPC_FLOOR_TRIP_MA 16'h0064
`define PPC_CLK_HZ 25000000
`define PPC_RETRY_MS 200
`define PPC_CC_RESTORE_MS 200
`define PPC_DISCHARGE_MS 200
`define PPC_TICK_MS 1
`endif

// File: sim/ppc_dev_model.sv
// Portable device model drawing power from the port
`timescale 1ns/1ps
module ppc_dev_model (
  // Clock
  input wire clock,
  // Port state from the controller
  input wire portSwitchOn,
  input wire dischargeOn,
  // Scenario control: bus capacitance that will not drain
  input wire slowDrain,
  // Load and bus level seen by the controller
  output logic [15:0] busCurrentMa,
  output logic vbusBelowCheckLevel
);
  logic [3:0] vbusLvl_q = 4'h0;
  // Heavy load: full-scale current, but only while the switch feeds it
  assign busCurrentMa = portSwitchOn ? 16'hffff : 16'h0000;
  // Bleeding wins over charging, so a window sees the level fall unless slowDrain is set
  always @(posedge clock) begin
    if (dischargeOn && !slowDrain && vbusLvl_q != 4'h0)
      vbusLvl_q <= vbusLvl_q - 4'h1;
    else if (portSwitchOn)
      vbusLvl_q <= 4'hf;
  end
  assign vbusBelowCheckLevel = (vbusLvl_q == 4'h0);
endmodule

// File: sim/ppc_ctrl_monitor.sv
// Assertions on the port power controller ports
`timescale 1ns/1ps
module ppc_ctrl_monitor #(parameter LIMIT_W = 3) (
  // Clock, reset and bus
  input wire clock,
  input wire srst,
  input wire s_axi_awvalid,
  input wire s_axi_wvalid,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_rvalid,
  // Pins and switch state
  input wire overShutdownTemp,
  input wire portPowerRequest,
  input wire portSwitchOn,
  input wire [LIMIT_W-1:0] portCurrentLimit,
  input wire constantCurrentLimiting,
  input wire [15:0] ccCurrentFloor,
  input wire dischargeOn,
  input wire errorState,
  input wire forceSleep,
  input wire dataPathSwitchEn,
  input wire monitorEn,
  input wire profileEnable
);
  // One clock domain, synchronous reset
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  wr_answer_a: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid)
    else $error("write not answered");
  rd_answer_a: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
    else $error("read not answered");
  shutdown_off_a: assert property (overShutdownTemp [*5] |-> !portSwitchOn)
    else $error("switch on while too hot");
  // Switch output is registered one cycle behind the step, so look on the next edge
  step_open_a: assert property (portCurrentLimit < $past(portCurrentLimit) |=> !portSwitchOn)
    else $error("limit stepped with switch closed");
  trip_floor_a: assert property (ccCurrentFloor != 16'h0000 |->
    ccCurrentFloor == 16'h0064 && !constantCurrentLimiting) else $error("bad floor");
  sleep_stop_a: assert property (forceSleep |->
    !portSwitchOn && !profileEnable && !dataPathSwitchEn && !monitorEn) else $error("sleep leak");
  monitor_keep_a: assert property (!monitorEn |-> forceSleep)
    else $error("monitoring stopped outside sleep");
  release_disch_a: assert property ($fell(portPowerRequest) |-> ##[1:8] dischargeOn)
    else $error("no discharge on release");
  disch_fail_a: assert property ($rose(errorState) |-> $past(dischargeOn) || $past(dischargeOn, 2))
    else $error("error without discharge");
  // Main scenarios reached
  cover property (forceSleep);
  cover property ($rose(errorState));
  cover property (ccCurrentFloor == 16'h0064 && portCurrentLimit == '0);
endmodule
bind ppc_port_power_protection_ctrl ppc_ctrl_monitor #(.LIMIT_W(LIMIT_W)) mon_u (
  .clock, .srst, .s_axi_awvalid, .s_axi_wvalid, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_rvalid, .overShutdownTemp, .portPowerRequest, .portSwitchOn, .portCurrentLimit,
  .constantCurrentLimiting, .ccCurrentFloor, .dischargeOn, .errorState, .forceSleep,
  .dataPathSwitchEn, .monitorEn, .profileEnable
);

// File: sim/tb.sv
// Self-checking bench for the port power controller
`timescale 1ns/1ps
`include "ppc_map.vh"
module tb;
  typedef struct {logic wr; logic [11:0] a; logic [31:0] d; logic [1:0] rsp;} ppc_row_t;
  logic clock, srst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic overRegTemp, regTempReleased, overShutdownTemp, shutdownTempReleased, errorRecover;
  logic sourceUndervoltage, vbusBelowCheckLevel, portPowerRequest, removalDetect, sleepCommand;
  logic profileApply, bypassSelected, activeState, chargerCycleAccepted, controlsChanged;
  logic portSwitchOn, constantCurrentLimiting, dischargeOn, errorState, profileEnable, slowDrain;
  logic forceSleep, dataPathSwitchEn, monitorEn, bypassBlock, alertN;
  logic [15:0] busCurrentMa, ccCurrentFloor;
  logic [2:0] portCurrentLimit;
  int nErrors = 0;
  int nTests = 0;
  // Reads give the expected word, writes the word sent
  ppc_row_t rows[10] = '{
    '{1'b0, `PPC_OFF_CTRL, 32'h00000010, 2'h0}, '{1'b0, `PPC_OFF_LIMIT, 32'h00000007, 2'h0},
    '{1'b0, `PPC_OFF_REACHED_FLAG_A, 32'h0000ffff, 2'h0}, '{1'b0, `PPC_OFF_CHARGE, 32'h0, 2'h0},
    '{1'b1, `PPC_OFF_REACHED_FLAG_A, 32'h00001234, 2'h0}, '{1'b0, `PPC_OFF_REACHED_FLAG_A, 32'h00001234, 2'h0},
    '{1'b1, `PPC_OFF_CTRL, 32'h00000016, 2'h0}, '{1'b0, `PPC_OFF_CTRL, 32'h00000010, 2'h0},
    '{1'b1, 12'h014, 32'h00000055, 2'h2}, '{1'b0, 12'h014, 32'h0, 2'h2}};
  // Alert, switch, sleep, data path, monitoring for each action code
  logic [4:0] rationExp[4] = '{5'b01011, 5'b00011, 5'b10100, 5'b11011};
  ppc_port_power_protection_ctrl #(.RETRY_CYCLES(20), .RESTORE_CYCLES(20),
    .DISCHARGE_CYCLES(20), .TICK_CYCLES(4)) dut_u (.*);
  ppc_dev_model dev_u (.clock, .portSwitchOn, .dischargeOn, .slowDrain, .busCurrentMa,
    .vbusBelowCheckLevel);
  // 25 MHz clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      nErrors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Address and data offered together, held until taken
  task axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do @(posedge clock); while (s_axi_awready !== 1'b1);
    {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
    do @(posedge clock); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge clock); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clock); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task close_out;
    $display("tests %0d errors %0d", nTests, nErrors);
    if (nErrors == 0 && nTests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Hang guard, several times the expected run
  initial begin
    cyc(8000);
    nErrors++;
    close_out();
  end
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {overRegTemp, regTempReleased, overShutdownTemp, shutdownTempReleased, errorRecover} = '0;
    {sourceUndervoltage, portPowerRequest, removalDetect, sleepCommand, profileApply} = '0;
    {bypassSelected, activeState, chargerCycleAccepted, controlsChanged, slowDrain} = '0;
    srst = 1'b1;
    cyc(1);
    #1;
    chk({portSwitchOn, dischargeOn, errorState, alertN, dataPathSwitchEn, monitorEn}, 6'h07);
    @(posedge clock);
    srst <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        axw(rows[i].a, rows[i].d, rsp);
      end else begin
        axr(rows[i].a, rd, rsp);
        chk(rd, rows[i].d);
      end
      chk(rsp, rows[i].rsp);
    end
    $display("register rows done");
    {activeState, portPowerRequest} <= 2'h3;
    axw(`PPC_OFF_CTRL, 32'h00000008, rsp);
    cyc(10);
    chk({portSwitchOn, constantCurrentLimiting}, 2'h3);
    overRegTemp <= 1'b1;
    cyc(700);
    chk({portSwitchOn, constantCurrentLimiting, portCurrentLimit, dischargeOn}, 6'h20);
    chk(ccCurrentFloor, 16'h0064);
    {overRegTemp, regTempReleased} <= 2'h1;
    cyc(10);
    chk(constantCurrentLimiting, 1'b0);
    cyc(30);
    chk({constantCurrentLimiting, portCurrentLimit}, 4'hf);
    axw(`PPC_OFF_CTRL, 32'h0, rsp);
    {overRegTemp, regTempReleased} <= 2'h2;
    cyc(8);
    chk({portSwitchOn, portCurrentLimit}, 4'h6);
    {overRegTemp, regTempReleased} <= 2'h1;
    // The running retry window ends before the recheck, so wait it out
    cyc(30);
    chk(portCurrentLimit, 3'h7);
    regTempReleased <= 1'b0;
    overShutdownTemp <= 1'b1;
    cyc(6);
    chk(portSwitchOn, 1'b0);
    overShutdownTemp <= 1'b0;
    cyc(6);
    chk(portSwitchOn, 1'b0);
    shutdownTempReleased <= 1'b1;
    cyc(30);
    chk(portSwitchOn, 1'b1);
    shutdownTempReleased <= 1'b0;
    $display("thermal done");
    for (int k = 0; k < 7; k++) begin
      case (k)
        0: portPowerRequest <= 1'b0;
        1: removalDetect <= 1'b1;
        2: sleepCommand <= 1'b1;
        3: profileApply <= 1'b1;
        4: sourceUndervoltage <= 1'b1;
        5: bypassSelected <= 1'b1;
        6: bypassSelected <= 1'b0;
      endcase
      cyc(8);
      chk(dischargeOn, 1'b1);
      {removalDetect, sleepCommand, profileApply, sourceUndervoltage} <= 4'h0;
      portPowerRequest <= 1'b1;
      cyc(40);
      chk({dischargeOn, errorState}, 2'h0);
    end
    axw(`PPC_OFF_CTRL, 32'h00000004, rsp);
    cyc(4);
    chk(dischargeOn, 1'b1);
    {slowDrain, removalDetect} <= 2'h3;
    cyc(60);
    chk(errorState, 1'b1);
    axr(`PPC_OFF_STATUS, rd, rsp);
    chk(rd[2], 1'b1);
    {slowDrain, removalDetect, errorRecover} <= 3'h1;
    cyc(8);
    chk({errorState, dischargeOn}, 2'h1);
    errorRecover <= 1'b0;
    cyc(40);
    $display("discharge done");
    axw(`PPC_OFF_REACHED_FLAG_A, 32'h0, rsp);
    for (int b = 0; b < 4; b++) begin
      axw(`PPC_OFF_CTRL, 32'h1 | (b << 4), rsp);
      cyc(12);
      chk({alertN, portSwitchOn, forceSleep, dataPathSwitchEn, monitorEn}, rationExp[b]);
      chk(errorState, 1'b0);
      if (b == 1)
        chk(bypassBlock, 1'b1);
      chk(profileEnable, b == 0 || b == 3);
      axr(`PPC_OFF_STATUS, rd, rsp);
      chk(rd[3], 1'b1);
      axw(`PPC_OFF_CTRL, b << 4, rsp);
      cyc(12);
      chk({alertN, forceSleep}, 2'h2);
    end
    axw(`PPC_OFF_REACHED_FLAG_A, 32'h1, rsp);
    axw(`PPC_OFF_CTRL, 32'h00000031, rsp);
    cyc(400);
    axr(`PPC_OFF_CHARGE, rd, rsp);
    chk(rd, 32'h1);
    axw(`PPC_OFF_CTRL, 32'h00000033, rsp);
    axr(`PPC_OFF_CHARGE, rd, rsp);
    chk(rd, 32'h0);
    $display("rationing done");
    // Hot during an accepted charger cycle drops the profile until a control change
    {chargerCycleAccepted, overRegTemp} <= 2'h3;
    cyc(6);
    chk(profileEnable, 1'b0);
    overRegTemp <= 1'b0;
    cyc(6);
    chk(profileEnable, 1'b0);
    controlsChanged <= 1'b1;
    cyc(6);
    chk(profileEnable, 1'b1);
    $display("profile drop done");
    close_out();
  end
endmodule
